// >>> hw/cmu_defines.vh
// Constants for the configuration-mode unlock and indexed option registers.
// Assumes a 10-bit host I/O address and an 8-bit data bus.
`ifndef CMU_DEFINES_VH
`define CMU_DEFINES_VH
`define CMU_INDEX_PORT   10'h3f0
`define CMU_DATA_PORT    10'h3f1
`define CMU_KEY_ENTER    8'h55
`define CMU_KEY_EXIT     8'haa
`define CMU_IDX_W        4
`define CMU_IDX_RESET    4'h0
`define CMU_DEF_CR0      8'h3b
`define CMU_DEF_CR1      8'h9f
`define CMU_DEF_CR2      8'hdc
`define CMU_DEF_CR3      8'h78
`define CMU_DEF_CRD      8'h63
`define CMU_DEF_CRE      8'h01
`define CMU_DEF_CR6      8'hff
`define CMU_DEF_ZERO     8'h00
`endif

// >>> hw/cmu_option_reg.v
// One indexed option register with its power-up default.
// Assumes the power-on reset is separate from the ordinary reset input.
`timescale 1ns/1ns
module cmu_option_reg
#(
    parameter [7:0] DEFAULT = 8'h00
)
(
    input  wire       clk,     // Device clock.
    input  wire       por,     // Power-on reset, async, active high.
    input  wire       wr_en,   // Write strobe for this register.
    input  wire [7:0] wr_data, // Data to store.
    output reg  [7:0] q_reg    // Stored value.
);

    // Only power-up loads the default; the ordinary reset never reaches here.
    always @(posedge clk or posedge por)
    begin
        if (por)
            q_reg <= DEFAULT;
        else if (wr_en)
            q_reg <= wr_data;
    end

endmodule // cmu_option_reg

// >>> hw/cmu_unlock.v
// Configuration-mode unlock, index pointer and sixteen option registers.
// Assumes host I/O strobes are synchronous one-cycle pulses on clk.
//
// Contract
// - Two back-to-back 55h writes to index port enter configuration mode.
// - Any other write between the two keys restarts the unlock sequence.
// - Sixteen option registers, numbered 0 to F, are indexed in mode.
// - In mode, index port write selects the target option register.
// - Data port reads and writes reach the selected option register.
// - Writing AAh to index port in mode leaves configuration mode.
// - Power-up starts outside configuration mode with default options.
// - Host loads index pointer before using the data port.
// - Option registers take defaults at power-up only, not reset.
`timescale 1ns/1ns
`include "cmu_defines.vh"
module cmu_unlock
(
    input  wire       clk,        // Device clock, 25 MHz.
    input  wire       por,        // Power-on reset, async, active high.
    input  wire       rst,        // Ordinary reset, async, active high.
    input  wire [9:0] io_addr,    // Host I/O address.
    input  wire [7:0] io_wdata,   // Host write data.
    input  wire       io_wr,      // Host write strobe, one cycle.
    input  wire       io_rd,      // Host read strobe, one cycle.
    output reg  [7:0] io_rdata,   // Read data, registered.
    output reg        io_rvalid,  // Read data valid, one cycle.
    output wire       cfg_mode    // High while in configuration mode.
);

    // One-hot states of the unlock sequence.
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_KEY1 = 3'b010;
    localparam [2:0] ST_CFG  = 3'b100;

    reg  [2:0]              state_reg;
    reg  [2:0]              state_next;
    reg  [`CMU_IDX_W-1:0]   index_reg;
    wire                    any_acc;
    wire                    idx_wr;
    wire                    dat_wr;
    wire                    dat_rd;
    wire [7:0]              opt_q [0:15];
    reg  [15:0]             wr_sel;
    reg  [7:0]              rd_mux;
    wire                    key_enter;
    wire                    key_exit;
    wire                    other_acc;

    assign any_acc = io_wr | io_rd;
    assign idx_wr  = io_wr && (io_addr == `CMU_INDEX_PORT);
    assign dat_wr  = io_wr && (io_addr == `CMU_DATA_PORT) && cfg_mode;
    assign dat_rd  = io_rd && (io_addr == `CMU_DATA_PORT) && cfg_mode;
    assign cfg_mode = state_reg[2];

    // Key decodes. Both keys count only at the index port, so a key value
    // written to the data port is plain data or a breaking write.
    assign key_enter = idx_wr && (io_wdata == `CMU_KEY_ENTER);
    assign key_exit  = idx_wr && (io_wdata == `CMU_KEY_EXIT);

    // Any access that is not the second enter key breaks a pending pair.
    // Reads count too, so a status poll slipped between the keys also
    // restarts the pair instead of being silently ignored.
    assign other_acc = any_acc && !key_enter;

    // Unlock sequencing. The two enter keys must not be split by any other
    // access; idle cycles between them do not break the pair.
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                // The first enter key arms the sequence.
                if (key_enter)
                    state_next = ST_KEY1;
            end
            ST_KEY1:
            begin
                // The second key completes it; any other access restarts.
                if (key_enter)
                    state_next = ST_CFG;
                else if (other_acc)
                    state_next = ST_IDLE;
            end
            ST_CFG:
            begin
                // Only the exit key leaves; index and data traffic stay.
                if (key_exit)
                    state_next = ST_IDLE;
            end
            default:
            begin
                // An illegal code falls back to the locked state.
                state_next = ST_IDLE;
            end
        endcase
    end

    // State register. Both resets return the block to the locked state, but
    // only por reloads the option registers; rst leaves them intact so that
    // a warm reset keeps the configuration the firmware chose.
    always @(posedge clk or posedge por or posedge rst)
    begin
        if (por || rst)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Index pointer. Only the low nibble is kept, so any byte selects one of
    // the sixteen entries. The exit key is consumed by the state machine and
    // must not also move the pointer. Outside mode the port is watched for
    // keys only and the pointer holds.
    always @(posedge clk or posedge por or posedge rst)
    begin
        if (por || rst)
        begin
            index_reg <= `CMU_IDX_RESET;
        end
        else if (idx_wr && cfg_mode && !key_exit)
        begin
            index_reg <= io_wdata[`CMU_IDX_W-1:0];
        end
    end

    // Power-up default table, entry n at bits 8n+7:8n. It must be a constant
    // because each register takes its entry as a parameter. Entries with no
    // fixed default power up as zero, a harmless value for reserved bits.
    localparam [8*16-1:0] DEFAULTS = {
        `CMU_DEF_ZERO,  // Entry 15.
        `CMU_DEF_CRE,   // Entry 14.
        `CMU_DEF_CRD,   // Entry 13.
        `CMU_DEF_ZERO,  // Entry 12.
        `CMU_DEF_ZERO,  // Entry 11.
        `CMU_DEF_ZERO,  // Entry 10.
        `CMU_DEF_ZERO,  // Entry 9.
        `CMU_DEF_ZERO,  // Entry 8.
        `CMU_DEF_ZERO,  // Entry 7.
        `CMU_DEF_CR6,   // Entry 6.
        `CMU_DEF_ZERO,  // Entry 5.
        `CMU_DEF_ZERO,  // Entry 4.
        `CMU_DEF_CR3,   // Entry 3.
        `CMU_DEF_CR2,   // Entry 2.
        `CMU_DEF_CR1,   // Entry 1.
        `CMU_DEF_CR0    // Entry 0.
    };

    // One-hot write select. Decoding once here keeps the sixteen enables
    // from each carrying its own comparator on the index.
    always @*
    begin
        wr_sel = 16'h0000;
        if (dat_wr)
            wr_sel[index_reg] = 1'h1;
    end

    // Sixteen option registers, each written only in mode. They sit on por
    // alone, so an ordinary reset cannot disturb a chosen configuration.
    // The price is that a wedged option can only be cleared by power-up.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_opt
            cmu_option_reg
            #(
                .DEFAULT (DEFAULTS[8*gi+7:8*gi])
            )
            u_reg
            (
                .clk     (clk),
                .por     (por),
                .wr_en   (wr_sel[gi]),
                .wr_data (io_wdata),
                .q_reg   (opt_q[gi])
            );
        end
    endgenerate

    // Read mux as a flat case. A four-bit index reaches every entry, but the
    // default keeps the process free of latches if the width ever grows.
    always @*
    begin
        case (index_reg)
            4'h0:    rd_mux = opt_q[0];
            4'h1:    rd_mux = opt_q[1];
            4'h2:    rd_mux = opt_q[2];
            4'h3:    rd_mux = opt_q[3];
            4'h4:    rd_mux = opt_q[4];
            4'h5:    rd_mux = opt_q[5];
            4'h6:    rd_mux = opt_q[6];
            4'h7:    rd_mux = opt_q[7];
            4'h8:    rd_mux = opt_q[8];
            4'h9:    rd_mux = opt_q[9];
            4'ha:    rd_mux = opt_q[10];
            4'hb:    rd_mux = opt_q[11];
            4'hc:    rd_mux = opt_q[12];
            4'hd:    rd_mux = opt_q[13];
            4'he:    rd_mux = opt_q[14];
            4'hf:    rd_mux = opt_q[15];
            default: rd_mux = 8'h00;
        endcase
    end

    // Read answer, registered so the host sees stable data for a cycle.
    // Reads outside mode, or at the index port, return zero with no valid,
    // so option contents never leak onto an unlocked bus.
    always @(posedge clk or posedge por or posedge rst)
    begin
        if (por || rst)
        begin
            io_rdata  <= 8'h00;
            io_rvalid <= 1'b0;
        end
        else
        begin
            io_rvalid <= dat_rd;
            io_rdata  <= dat_rd ? rd_mux : `CMU_DEF_ZERO;
        end
    end

endmodule // cmu_unlock

// >>> tb/cmu_host_model.sv
// Host model issuing one-cycle I/O write and read strobes.
// Assumes the device answers a read one clock after its strobe.
`timescale 1ns/1ns
module cmu_host_model
(
    input  wire       clk,      // Device clock.
    output reg  [9:0] io_addr,  // Address.
    output reg  [7:0] io_wdata, // Write data.
    output reg        io_wr,    // Write strobe.
    output reg        io_rd,    // Read strobe.
    input  wire [7:0] io_rdata, // Read data.
    input  wire       io_rvalid // Read valid.
);
    initial {io_addr, io_wdata, io_wr, io_rd} = 20'h0;
    // One access per call, so nothing slips between two key writes.
    task wr(input [9:0] a, input [7:0] d);
    begin
        @(negedge clk);
        {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
        @(negedge clk);
        {io_wr, io_wdata} = {1'b0, ~d}; // Stale data never repeats.
    end
    endtask
    task rd(input [9:0] a, output [7:0] q, output v);
    begin
        @(negedge clk);
        {io_addr, io_rd} = {a, 1'b1};
        @(negedge clk);
        {io_rd, q, v} = {1'b0, io_rdata, io_rvalid};
    end
    endtask
endmodule // cmu_host_model

// >>> tb/cmu_unlock_checker.sv
// Checks mode entry, exit and read answers of the unlock block.
// Assumes it is bound to cmu_unlock; por or rst masks every check.
`timescale 1ns/1ns
module cmu_unlock_checker
(
    input wire       clk,       // Clock.
    input wire       por,       // Power-on reset.
    input wire       rst,       // Reset.
    input wire [9:0] io_addr,   // Address.
    input wire [7:0] io_wdata,  // Write data.
    input wire       io_wr,     // Write strobe.
    input wire       io_rd,     // Read strobe.
    input wire [7:0] io_rdata,  // Read data.
    input wire       io_rvalid, // Read valid.
    input wire       cfg_mode   // Mode flag.
);
    default clocking @(posedge clk); endclocking
    default disable iff (por || rst);
    // Key write and idle cycle, the steps of the unlock sequence.
    sequence key_s; io_wr && io_addr == 10'h3f0 && io_wdata == 8'h55;
    endsequence
    sequence idle_s; !io_wr && !io_rd; endsequence
    enter_mode_a: assert property (
        !cfg_mode ##0 key_s ##1 idle_s ##1 key_s |=> cfg_mode)
        else $error("mode not entered");
    break_key_a: assert property (
        !cfg_mode && io_wr && !(io_addr == 10'h3f0 && io_wdata == 8'h55)
        |=> !cfg_mode [*2]) else $error("bad entry");
    exit_mode_a: assert property (
        cfg_mode && io_wr && io_addr == 10'h3f0 && io_wdata == 8'haa
        |=> !cfg_mode) else $error("no exit");
    read_answer_a: assert property (
        cfg_mode && io_rd && io_addr == 10'h3f1 |=> io_rvalid)
        else $error("no read answer");
    read_refuse_a: assert property (!(cfg_mode && io_rd &&
        io_addr == 10'h3f1) |=> !io_rvalid) else $error("stray valid");
    rdata_idle_a: assert property (!io_rvalid |-> io_rdata == 8'h00)
        else $error("stray data");
    mode_hold_a: assert property (cfg_mode && !io_wr |=> cfg_mode)
        else $error("mode lost");
    off_hold_a: assert property (!cfg_mode ##0 idle_s |=> !cfg_mode)
        else $error("mode rose idle");
endmodule // cmu_unlock_checker
bind cmu_unlock cmu_unlock_checker chk (.clk(clk), .por(por), .rst(rst),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .cfg_mode(cfg_mode));

// >>> tb/cmu_unlock_tb.sv
// Testbench for cmu_unlock: unlock, indexed access, exit and resets.
// Assumes the host model makes every I/O strobe of the device.
`timescale 1ns/1ns
module cmu_unlock_tb;
    reg         clk = 1'b0;
    reg         por = 1'b1;
    reg         rst = 1'b1;
    wire [9:0]  io_addr;
    wire [7:0]  io_wdata, io_rdata;
    wire        io_wr, io_rd, io_rvalid, cfg_mode;
    reg  [7:0]  q;
    reg         v;
    integer     n_mismatch = 0, cmp_count = 0, cyc = 0, i;
    // Power-up option values, index 0 in the top byte.
    localparam [127:0] DFLT = 128'h3b9fdc780000ff000000000000630100;
    always #20 clk = ~clk;
    cmu_host_model host (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid));
    cmu_unlock dut (.clk(clk), .por(por), .rst(rst), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid), .cfg_mode(cfg_mode));
    task chk(input [7:0] got, input [7:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task complete_run;
    begin
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // A hang is cut off long after the roughly 180 cycles needed.
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end
    // Break an entry, enter, walk all sixteen options, exit, then reset.
    initial
    begin
        repeat (20) @(negedge clk);
        {por, rst} = 2'b00;
        chk({7'h0, cfg_mode}, 8'h00);
        host.rd(10'h3f1, q, v);
        chk({7'h0, v}, 8'h00);
        host.wr(10'h3f0, 8'h55);
        host.wr(10'h3f1, 8'h00);
        host.wr(10'h3f0, 8'h55);
        chk({7'h0, cfg_mode}, 8'h00);
        host.wr(10'h3f0, 8'h55);
        chk({7'h0, cfg_mode}, 8'h01);
        for (i = 0; i < 16; i = i + 1)
        begin
            host.wr(10'h3f0, i[7:0]);
            host.rd(10'h3f1, q, v);
            chk(q, DFLT[127 - 8 * i -: 8]);
            chk({7'h0, v}, 8'h01);
            host.wr(10'h3f1, i[7:0] ^ 8'h5a);
            host.rd(10'h3f1, q, v);
            chk(q, i[7:0] ^ 8'h5a);
        end
        host.wr(10'h3f0, 8'haa);
        chk({7'h0, cfg_mode}, 8'h00);
        host.rd(10'h3f1, q, v);
        chk({v, q[6:0]}, 8'h00);
        chk(q, 8'h00);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk({7'h0, cfg_mode}, 8'h00);
        host.wr(10'h3f0, 8'h55);
        host.wr(10'h3f0, 8'h55);
        host.wr(10'h3f0, 8'h03);
        host.rd(10'h3f1, q, v);
        chk(q, 8'h59);
        por = 1'b1;
        @(negedge clk);
        por = 1'b0;
        chk({7'h0, cfg_mode}, 8'h00);
        host.wr(10'h3f0, 8'h55);
        host.wr(10'h3f0, 8'h55);
        host.wr(10'h3f0, 8'h03);
        host.rd(10'h3f1, q, v);
        chk(q, DFLT[103 -: 8]);
        complete_run;
    end
endmodule // cmu_unlock_tb
